// ### icm_defs.vh
// Constants for the input clock monitor
`ifndef ICM_DEFS_VH
`define ICM_DEFS_VH
// ===========================================================
// Timing
`define ICM_CLK_PERIOD_NS 4
`define ICM_INTERVAL_MS 128
`define ICM_INTERVAL_CYC ((`ICM_INTERVAL_MS * 1000000) / `ICM_CLK_PERIOD_NS)
`define ICM_FREQ_TOL_PPM 10000
`define ICM_PPM_DIV (1000000 / `ICM_FREQ_TOL_PPM)
`define ICM_MISS_SLOW 2
`define ICM_MISS_FAST 4
// ===========================================================
// Register offsets
`define ICM_OFS_CTRL 8'h00
`define ICM_OFS_VALID 8'h04
`define ICM_OFS_CHG 8'h08
`define ICM_OFS_IRQEN 8'h0c
`define ICM_OFS_PLLST 8'h10
`define ICM_OFS_ALARM 8'h14
`define ICM_OFS_STATE 8'h18
`define ICM_OFS_PROF 8'h20
`define ICM_OFS_ICFG 8'h40
`define ICM_OFS_LAST 8'h5c
// ===========================================================
// Fields
`define ICM_CTRL_FREQ_RANGE_ENABLE 0
`define ICM_CTRL_FPIN 1
`define ICM_CTRL_NOACTIVITY_LOSSOFLOCK 2
`define ICM_PLL_SRF 0
`define ICM_PLL_PSTATE 1
`define ICM_PLL_SLOCK 2
`define ICM_PLL_SNOIN 3
`define ICM_PROF_SIZE 7:0
`define ICM_PROF_ALARM 15:8
`define ICM_PROF_CLEAR 23:16
`define ICM_PROF_DECAY 25:24
`define ICM_ICFG_NOM 15:0
`define ICM_ICFG_FAST 16
`define ICM_ICFG_PROF 18:17
// ===========================================================
// Reset values and responses
`define ICM_CTRL_RST 3'h1
`define ICM_IRQEN_RST 12'h000
`define ICM_PROF_RST 26'h001080a
`define ICM_ICFG_RST 19'h00010
`define ICM_RESP_OKAY 2'h0
`define ICM_RESP_SLVERR 2'h2
`endif

// ### icm_input_clock_monitor.v
// Input clock monitor: range check, leaky buckets, fast monitors, AXI4-Lite registers
// Contract
// - Input invalid when its frequency is off nominal by over 10,000ppm.
// - Frequency range enable cleared stops all frequency invalidation.
// - Frequency measured against the master clock as timebase.
// - Real-time valid bit; any change latches a flag and may request interrupt.
// - Invalid inputs are never offered for automatic reference selection.
// - Secondary no-input flag set when no valid input exists.
// - Each input picks one of four bucket profiles, each fully programmable.
// - 128ms intervals; bucket fills at most once, on inactivity or frequency range error.
// - Fill when inactive over two cycles, or four for fast references.
// - Decay once per 1, 2, 4 or 8 clean intervals; none with fill.
// - Reaching alarm threshold sets activity alarm and invalidates input.
// - Decaying to clear threshold clears the activity alarm.
// - Bucket saturates at its profile size.
// - Fill events come from frequency range and activity monitors.
// - Each DPLL has a fast range and inactivity monitor on its reference.
// - Primary no-activity enters mini-holdover and latches reference failure.
// - Reference failure latch requests interrupt when enabled.
// - Failure pin follows the failure latch when pin enable set.
// - Loss-of-lock control off: no lock loss, nearest-edge tracking resumes.
// - Loss-of-lock control on: lose lock, latch change, relock phase/frequency.
// - Secondary never sets failure latch; may drop lock and latch change.
`timescale 1ns/10ps
`default_nettype none
`include "icm_defs.vh"
module icm_input_clock_monitor #(
   parameter NUM_INPUTS = 8,
   parameter INTERVAL_CYC = `ICM_INTERVAL_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [NUM_INPUTS-1:0] ref_clk_in,
   input wire [2:0] primary_ref_sel,
   input wire [2:0] secondary_ref_sel,
   input wire primary_phase_locked,
   input wire secondary_phase_locked,
   output wire [NUM_INPUTS-1:0] ref_eligible,
   output wire primary_holdover,
   output wire primary_lossoflock,
   output wire primary_nearest_edge,
   output wire secondary_lock_flag,
   output wire irq_req,
   output reg selected_ref_fail
);

   localparam [31:0] INT_LAST_W = INTERVAL_CYC - 1;
   localparam [24:0] INT_LAST = INT_LAST_W[24:0];

   // ===========================================================
   // Helpers
   function icm_map_ok;
      input [7:0] a;
      begin
         icm_map_ok = (a[1:0] == 2'h0) && ((a <= `ICM_OFS_STATE) ||
            ((a >= `ICM_OFS_PROF) && (a <= `ICM_OFS_LAST)));
      end
   endfunction

   function [31:0] icm_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] strb;
      integer k;
      begin
         icm_merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               icm_merge[k*8 +: 8] = wd[k*8 +: 8];
            end
         end
      end
   endfunction

   // ===========================================================
   // Registers
   reg [2:0] ctrl_r;
   reg [11:0] irqen_r;
   reg [25:0] prof_r [0:3];
   reg [18:0] icfg_r [0:NUM_INPUTS-1];
   reg [NUM_INPUTS-1:0] chg_r;
   reg [3:0] pll_r;
   reg [24:0] int_cnt_r;
   reg pfail_r;
   reg sfail_r;
   reg lol_r;
   reg sec_lock_r;
   wire [NUM_INPUTS-1:0] valid_w;
   wire [NUM_INPUTS-1:0] valid_nxt_w;
   wire [NUM_INPUTS-1:0] alarm_w;
   wire [NUM_INPUTS-1:0] inact_w;
   wire [NUM_INPUTS-1:0] fbad_w;
   wire freq_range_enable = ctrl_r[`ICM_CTRL_FREQ_RANGE_ENABLE];
   wire noactivity_lossoflock = ctrl_r[`ICM_CTRL_NOACTIVITY_LOSSOFLOCK];
   wire tick = (int_cnt_r == INT_LAST);
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
   wire wr_ok = icm_map_ok(s_axi_awaddr);
   wire [31:0] wr_word;
   wire [31:0] wr_mask;
   integer j;
   integer m;

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;

   // ===========================================================
   // Write path
   assign wr_word = icm_merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
   assign wr_mask = icm_merge(32'h00000000, 32'hffffffff, s_axi_wstrb);

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `ICM_CTRL_RST;
         irqen_r <= `ICM_IRQEN_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ICM_RESP_OKAY;
         for (j = 0; j < 4; j = j + 1) begin
            prof_r[j] <= `ICM_PROF_RST;
         end
         for (j = 0; j < NUM_INPUTS; j = j + 1) begin
            icfg_r[j] <= `ICM_ICFG_RST;
         end
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
            if (s_axi_awaddr == `ICM_OFS_CTRL) begin
               ctrl_r <= (ctrl_r & ~wr_mask[2:0]) | wr_word[2:0];
            end
            if (s_axi_awaddr == `ICM_OFS_IRQEN) begin
               irqen_r <= (irqen_r & ~wr_mask[11:0]) | wr_word[11:0];
            end
            for (j = 0; j < 4; j = j + 1) begin
               if (s_axi_awaddr == `ICM_OFS_PROF + j * 4) begin
                  prof_r[j] <= (prof_r[j] & ~wr_mask[25:0]) | wr_word[25:0];
               end
            end
            for (j = 0; j < NUM_INPUTS; j = j + 1) begin
               if (s_axi_awaddr == `ICM_OFS_ICFG + j * 4) begin
                  icfg_r[j] <= (icfg_r[j] & ~wr_mask[18:0]) | wr_word[18:0];
               end
            end
         end
      end
   end

   // ===========================================================
   // Interval timebase
   always @(posedge aclk) begin
      if (!aresetn) begin
         int_cnt_r <= 25'h0000000;
      end else begin
         int_cnt_r <= tick ? 25'h0000000 : int_cnt_r + 25'h0000001;
      end
   end

   // ===========================================================
   // Per-input monitors
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_in
         reg samp_r;
         reg seen_r;
         reg [17:0] since_r;
         reg fbad_r;
         reg fill_r;
         reg [7:0] bucket_r;
         reg [2:0] dec_cnt_r;
         reg alarm_r;
         reg valid_r;
         wire [18:0] cfg = icfg_r[gi];
         wire [25:0] prof = prof_r[cfg[`ICM_ICFG_PROF]];
         wire [17:0] nom = {2'h0, cfg[`ICM_ICFG_NOM]};
         wire [31:0] tol_w = nom / `ICM_PPM_DIV;
         wire [17:0] tol = tol_w[17:0];
         wire [31:0] miss_w = cfg[`ICM_ICFG_FAST] ? `ICM_MISS_FAST : `ICM_MISS_SLOW;
         wire [17:0] miss = miss_w[17:0];
         wire [17:0] lim = nom * miss;
         wire edge_in = ref_clk_in[gi] & ~samp_r;
         wire [17:0] period = since_r + 18'h00001;
         wire inact = since_r > lim;
         wire ferr = (period < nom - tol) | (period > nom + tol);
         wire fbad = freq_range_enable & fbad_r;
         wire fill_now = fill_r | inact | fbad;
         wire [3:0] dec_last = (4'h1 << prof[`ICM_PROF_DECAY]) - 4'h1;
         assign inact_w[gi] = inact;
         assign fbad_w[gi] = fbad;
         assign alarm_w[gi] = alarm_r;
         assign valid_nxt_w[gi] = ~alarm_r & ~fbad;
         assign valid_w[gi] = valid_r;
         always @(posedge aclk) begin
            if (!aresetn) begin
               samp_r <= 1'b1;
               seen_r <= 1'b0;
               since_r <= 18'h00000;
               fbad_r <= 1'b0;
               fill_r <= 1'b0;
               bucket_r <= 8'h00;
               dec_cnt_r <= 3'h0;
               alarm_r <= 1'b0;
               valid_r <= 1'b1;
            end else begin
               samp_r <= ref_clk_in[gi];
               seen_r <= seen_r | edge_in;
               since_r <= edge_in ? 18'h00000 : ((&since_r) ? since_r : period);
               fbad_r <= !freq_range_enable ? 1'b0 : (edge_in ? (ferr & seen_r) : fbad_r);
               fill_r <= tick ? 1'b0 : fill_now;
               valid_r <= valid_nxt_w[gi];
               if (tick) begin
                  if (fill_now) begin
                     dec_cnt_r <= 3'h0;
                     if (bucket_r < prof[`ICM_PROF_SIZE]) begin
                        bucket_r <= bucket_r + 8'h01;
                     end else begin
                        bucket_r <= prof[`ICM_PROF_SIZE];
                     end
                  end else if (dec_cnt_r == dec_last[2:0]) begin
                     dec_cnt_r <= 3'h0;
                     if (bucket_r != 8'h00) begin
                        bucket_r <= bucket_r - 8'h01;
                     end
                  end else begin
                     dec_cnt_r <= dec_cnt_r + 3'h1;
                  end
               end
               if (!alarm_r && bucket_r >= prof[`ICM_PROF_ALARM]) begin
                  alarm_r <= 1'b1;
               end else if (alarm_r && bucket_r <= prof[`ICM_PROF_CLEAR]) begin
                  alarm_r <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign ref_eligible = valid_w;

   // ===========================================================
   // Fast activity monitors and DPLL reactions
   wire pfail = inact_w[primary_ref_sel] | fbad_w[primary_ref_sel];
   wire sfail = inact_w[secondary_ref_sel] | fbad_w[secondary_ref_sel];
   wire pev = pfail & ~pfail_r;
   wire sev = sfail & ~sfail_r;
   wire lol_set = pev & noactivity_lossoflock;
   wire lol_clr = lol_r & ~pfail & primary_phase_locked;
   wire slock_nxt = (sev & noactivity_lossoflock) ? 1'b0 : ((~sfail & secondary_phase_locked) ? 1'b1 : sec_lock_r);

   assign primary_holdover = pfail_r;
   assign primary_lossoflock = lol_r;
   assign primary_nearest_edge = ~lol_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         pfail_r <= 1'b0;
         sfail_r <= 1'b0;
         lol_r <= 1'b0;
         sec_lock_r <= 1'b0;
      end else begin
         pfail_r <= pfail;
         sfail_r <= sfail;
         sec_lock_r <= slock_nxt;
         if (lol_set) begin
            lol_r <= 1'b1;
         end else if (lol_clr) begin
            lol_r <= 1'b0;
         end
      end
   end

   assign secondary_lock_flag = sec_lock_r;

   // ===========================================================
   // Latched flags, set wins over clear
   wire clr_chg = wr_go & (s_axi_awaddr == `ICM_OFS_CHG);
   wire clr_pll = wr_go & (s_axi_awaddr == `ICM_OFS_PLLST);
   wire [NUM_INPUTS-1:0] chg_set = valid_w ^ valid_nxt_w;
   wire [3:0] pll_set;

   assign pll_set[`ICM_PLL_SRF] = pev;
   assign pll_set[`ICM_PLL_PSTATE] = lol_set | lol_clr;
   assign pll_set[`ICM_PLL_SLOCK] = slock_nxt ^ sec_lock_r;
   assign pll_set[`ICM_PLL_SNOIN] = ~|valid_w;

   always @(posedge aclk) begin
      if (!aresetn) begin
         chg_r <= {NUM_INPUTS{1'b0}};
         pll_r <= 4'h0;
         selected_ref_fail <= 1'b0;
      end else begin
         chg_r <= (chg_r & ~(clr_chg ? wr_word[NUM_INPUTS-1:0] : {NUM_INPUTS{1'b0}})) | chg_set;
         pll_r <= (pll_r & ~(clr_pll ? wr_word[3:0] : 4'h0)) | pll_set;
         selected_ref_fail <= ctrl_r[`ICM_CTRL_FPIN] & pll_r[`ICM_PLL_SRF];
      end
   end

   assign irq_req = |({pll_r, chg_r} & irqen_r);

   // ===========================================================
   // Read path
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ICM_RESP_OKAY;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= icm_map_ok(s_axi_araddr) ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
               `ICM_OFS_CTRL: s_axi_rdata <= {29'h0, ctrl_r};
               `ICM_OFS_VALID: s_axi_rdata <= {{(32-NUM_INPUTS){1'b0}}, valid_w};
               `ICM_OFS_CHG: s_axi_rdata <= {{(32-NUM_INPUTS){1'b0}}, chg_r};
               `ICM_OFS_IRQEN: s_axi_rdata <= {20'h0, irqen_r};
               `ICM_OFS_PLLST: s_axi_rdata <= {28'h0, pll_r};
               `ICM_OFS_ALARM: s_axi_rdata <= {{(32-NUM_INPUTS){1'b0}}, alarm_w};
               `ICM_OFS_STATE: s_axi_rdata <= {28'h0, sec_lock_r, lol_r, pfail_r, pfail};
               default: begin
                  for (m = 0; m < 4; m = m + 1) begin
                     if (s_axi_araddr == `ICM_OFS_PROF + m * 4) begin
                        s_axi_rdata <= {6'h0, prof_r[m]};
                     end
                  end
                  for (m = 0; m < NUM_INPUTS; m = m + 1) begin
                     if (s_axi_araddr == `ICM_OFS_ICFG + m * 4) begin
                        s_axi_rdata <= {13'h0, icfg_r[m]};
                     end
                  end
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ### icm_input_clock_monitor_properties.sv
// Port assertions for the input clock monitor
`timescale 1ns/10ps
`default_nettype none
module icm_checker #(parameter NUM_INPUTS = 8) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_INPUTS-1:0] ref_eligible,
   input wire logic primary_holdover,
   input wire logic primary_lossoflock,
   input wire logic primary_nearest_edge,
   input wire logic irq_req
);
   // ==========================================
   // Bus and status relations
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_reset_state: assert property (disable iff (1'b0) !aresetn |=> &ref_eligible && !irq_req && !primary_lossoflock)
      else $error("state after reset wrong");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write answer missing");
   chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_aw_pairing: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && s_axi_wready)
      else $error("write taken unpaired");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
      else $error("read answer dropped");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   chk_nearest_edge: assert property (primary_nearest_edge == !primary_lossoflock)
      else $error("nearest edge mode wrong");
   chk_lol_holdover: assert property ($rose(primary_lossoflock) |-> ##[0:2] primary_holdover)
      else $error("lock loss without holdover");
endmodule
bind icm_input_clock_monitor icm_checker #(.NUM_INPUTS(NUM_INPUTS)) u_icm_checker (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_eligible(ref_eligible),
   .primary_holdover(primary_holdover), .primary_lossoflock(primary_lossoflock),
   .primary_nearest_edge(primary_nearest_edge), .irq_req(irq_req));
`default_nettype wire

// ### icm_ref_clk_model.sv
// Reference clock sources feeding the input clock monitor
`timescale 1ns/10ps
`default_nettype none
module icm_ref_clk_model #(parameter int N = 8) (
   input wire logic aclk,
   input wire logic [N-1:0] stop,
   input wire logic [N-1:0] slow,
   output wire logic [N-1:0] ref_clk
);
   logic [N-1:0] clk_r = '0;
   logic [3:0] cnt_r [N] = '{default: 4'h0};
   // ==========================================
   // Period 16 cycles, 20 when slow, frozen while stopped
   always @(posedge aclk) begin
      for (int i = 0; i < N; i++) begin
         if (stop[i]) begin
            cnt_r[i] <= 4'h0;
         end else if (cnt_r[i] == (slow[i] ? 4'h9 : 4'h7)) begin
            cnt_r[i] <= 4'h0;
            clk_r[i] <= ~clk_r[i];
         end else begin
            cnt_r[i] <= cnt_r[i] + 4'h1;
         end
      end
   end
   assign ref_clk = clk_r;
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the input clock monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, stop = 8'h00, slow = 8'h00;
   logic [31:0] wdata = 32'h0, rd_d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic plock = 1'b1, slock_in = 1'b1;
   logic [2:0] psel = 3'h2, ssel = 3'h4;
   logic [1:0] resp;
   wire logic awready, wready, bvalid, arready, rvalid, hold, lol, near, slock, irq, fpin;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdat;
   wire logic [7:0] elig, ref_clk;
   int err_count = 0, num_checks = 0;
   logic [41:0] rows [11] = '{{8'h00, 32'h1, 2'h0}, {8'h0c, 32'h0, 2'h0}, {8'h20, 32'h0001080a, 2'h0},
      {8'h2c, 32'h0001080a, 2'h0}, {8'h40, 32'h10, 2'h0}, {8'h5c, 32'h10, 2'h0}, {8'h04, 32'hff, 2'h0},
      {8'h14, 32'h0, 2'h0}, {8'h1c, 32'h0, 2'h2}, {8'h22, 32'h0, 2'h2}, {8'h60, 32'h0, 2'h2}};
   always #2 aclk = ~aclk;
   icm_ref_clk_model #(.N(8)) u_icm_ref_clk_model (.aclk(aclk), .stop(stop), .slow(slow), .ref_clk(ref_clk));
   icm_input_clock_monitor #(.NUM_INPUTS(8), .INTERVAL_CYC(64)) u_icm_input_clock_monitor (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clk_in(ref_clk), .primary_ref_sel(psel),
      .secondary_ref_sel(ssel), .primary_phase_locked(plock), .secondary_phase_locked(slock_in),
      .ref_eligible(elig), .primary_holdover(hold), .primary_lossoflock(lol), .primary_nearest_edge(near),
      .secondary_lock_flag(slock), .irq_req(irq), .selected_ref_fail(fpin));
   // ==========================================
   // Helpers
   task automatic results;
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdat;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, rd_d, resp);
      chk(rd_d, exp);
   endtask
   // ==========================================
   // Tests
   initial begin
      tick(12);
      aresetn <= 1'b1;
      tick(2);
      chk({near, irq, fpin, lol, hold, elig}, 13'h10ff);
      foreach (rows[i]) begin
         rd(rows[i][41:34], rd_d, resp);
         chk(rd_d, rows[i][33:2]);
         chk(resp, rows[i][1:0]);
      end
      slow <= 8'h02;
      tick(80);
      chk(elig, 8'hfd);
      rdchk(8'h08, 32'h2);
      wr(8'h0c, 32'h2);
      chk(irq, 1'b1);
      wr(8'h08, 32'h2);
      chk(irq, 1'b0);
      wr(8'h00, 32'h0);
      tick(40);
      chk(elig, 8'hff);
      slow <= 8'h00;
      wr(8'h00, 32'h7);
      wr(8'h24, 32'h01000204);
      wr(8'h4c, 32'h00020010);
      rdchk(8'h24, 32'h01000204);
      rdchk(8'h4c, 32'h00020010);
      wr(8'h0c, 32'h100);
      tick(64);
      wr(8'h10, 32'hf);
      wr(8'h08, 32'hff);
      chk(slock, 1'b1);
      stop <= 8'hff;
      plock <= 1'b0;
      slock_in <= 1'b0;
      tick(64);
      chk({hold, fpin, irq, lol, near, slock}, 6'h3c);
      tick(180);
      rdchk(8'h14, 32'h08);
      tick(690);
      chk(elig, 8'h00);
      rdchk(8'h14, 32'hff);
      rdchk(8'h04, 32'h00);
      rdchk(8'h10, 32'hf);
      rdchk(8'h08, 32'hff);
      stop <= 8'h00;
      plock <= 1'b1;
      slock_in <= 1'b1;
      tick(64);
      chk({hold, lol, near}, 3'h1);
      tick(320);
      rdchk(8'h14, 32'hff);
      tick(380);
      rdchk(8'h14, 32'h00);
      chk(elig, 8'hff);
      results();
   end
   // ==========================================
   // Watchdog
   initial begin
      #40000;
      err_count++;
      results();
   end
endmodule
`default_nettype wire
